// *** logic/ssp_consts.vh ***
// Purpose: Constants of the synchronous serial port (SPI / I2C slave)
// Assumes: Included by sync_serial_port.v only
// Notes: Register indices sit on the plain register port address
`ifndef SSP_CONSTS_VH
`define SSP_CONSTS_VH

// ----------------------------------------------------------------
// Register indices
// ----------------------------------------------------------------
`define SSP_REG_BUFFER 3'h0
`define SSP_REG_CONTROL 3'h1
`define SSP_REG_STATUS 3'h2
`define SSP_REG_IRQ 3'h3
`define SSP_REG_ADDRESS 3'h4

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define SSP_CTL_WRITE_COLLISION 7
`define SSP_CTL_OVF 6
`define SSP_CTL_EN 5
`define SSP_CTL_CKP 4
`define SSP_CTL_RESET 8'h00

// ----------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------
`define SSP_STA_SMP 7
`define SSP_STA_CKE 6
`define SSP_STA_DA 5
`define SSP_STA_STOP 4
`define SSP_STA_START 3
`define SSP_STA_RW 2
`define SSP_STA_BF 0
`define SSP_STA_RESET 8'h00

// ----------------------------------------------------------------
// Irq register fields
// ----------------------------------------------------------------
`define SSP_IRQ_FLAG 0
`define SSP_IRQ_ENABLE 1

// ----------------------------------------------------------------
// Mode field codes
// ----------------------------------------------------------------
`define SSP_MODE_MDIV4 4'h0
`define SSP_MODE_MDIV16 4'h1
`define SSP_MODE_MDIV64 4'h2
`define SSP_MODE_MTMR2 4'h3
`define SSP_MODE_SPI_SS 4'h4
`define SSP_MODE_SPI_NOSS 4'h5
`define SSP_MODE_I2C_7 4'h6
`define SSP_MODE_I2C_10 4'h7
`define SSP_MODE_I2C_FWM 4'hb
`define SSP_MODE_I2C_7SP 4'he
`define SSP_MODE_I2C_10SP 4'hf

// ----------------------------------------------------------------
// Master clock half periods in clk cycles (bit rate clk/4, /16, /64)
// ----------------------------------------------------------------
`define SSP_HALF_DIV4 6'h02
`define SSP_HALF_DIV16 6'h08
`define SSP_HALF_DIV64 6'h20
`define SSP_BITS 4'h8
`define SSP_TOGGLES 5'h10

`endif

// *** logic/sync_serial_port.v ***
// Purpose: Synchronous serial port, SPI master/slave or I2C slave, behind a plain register port
// Assumes: clk is 20 MHz; all pins are asynchronous and pass two flip-flops first
// Notes: Output enables are active low; I2C transmit and clock stretching are not built
//
// Chosen here: the register offsets and the strobed register port.
`timescale 1ns/1ps
`include "ssp_consts.vh"

module sync_serial_port (
  input wire clk, // 20 MHz clock
  input wire sys_rst, // Synchronous reset, active high
  input wire [2:0] regAddr, // Register index
  input wire [7:0] regWrData, // Write data
  input wire regWr, // Write strobe
  input wire regRd, // Read strobe
  output reg [7:0] regRdData, // Read data, one cycle after the strobe
  input wire sleepMode, // Device is asleep
  input wire tmr2Tick, // Timer pulse for the timer-driven master rate
  output reg portIrq, // Flag and enable, wakes the device
  input wire sckIn, // Serial clock pin level
  output reg sckOut, // Serial clock driven in master mode
  output reg sckOe_n, // Serial clock output enable
  input wire sdiIn, // Serial data in
  output reg sdoOut, // Serial data out
  output reg sdoOe_n, // Serial data out enable
  input wire ssIn_n, // Slave select pin
  input wire sdoDirIn, // Data output pin set as input
  input wire sckDirIn, // Clock pin set as input
  input wire sdaIn, // I2C data pin level
  output reg sdaOut, // I2C data driven level, always low
  output reg sdaOe_n, // I2C data output enable
  input wire sclIn, // I2C clock pin level
  output reg sclOut, // I2C clock driven level, always low
  output reg sclOe_n, // I2C clock output enable
  input wire sdaDirIn // I2C data pin set as input
);

  localparam ST_IDLE = 4'h1;
  localparam ST_ADDR = 4'h2;
  localparam ST_DATA = 4'h4;
  localparam ST_ACK = 4'h8;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  reg [4:0] pinMeta_q;
  reg [4:0] pinSync_q;
  reg [4:0] pinPrev_q;
  always @(posedge clk) begin
    if (sys_rst) begin
      // Idle levels of the pins, so no false edge follows reset
      pinMeta_q <= 5'h0f;
      pinSync_q <= 5'h0f;
      pinPrev_q <= 5'h0f;
    end else begin
      pinMeta_q <= {sckIn, sdiIn, ssIn_n, sdaIn, sclIn};
      pinSync_q <= pinMeta_q;
      pinPrev_q <= pinSync_q;
    end
  end
  wire sckS = pinSync_q[4];
  wire sdiS = pinSync_q[3];
  wire ssS_n = pinSync_q[2];
  wire sdaS = pinSync_q[1];
  wire sclS = pinSync_q[0];
  wire sckRise = sckS & ~pinPrev_q[4];
  wire sckFall = ~sckS & pinPrev_q[4];
  wire sdaRise = sdaS & ~pinPrev_q[1];
  wire sdaFall = ~sdaS & pinPrev_q[1];
  wire sclRise = sclS & ~pinPrev_q[0];
  wire sclFall = ~sclS & pinPrev_q[0];

  // ----------------------------------------------------------------
  // Registers and decode
  // ----------------------------------------------------------------
  reg [7:0] ctrl_q;
  reg [7:0] stat_q;
  reg [7:0] buf_q;
  reg [7:0] addr_q;
  reg irqFlag_q;
  reg irqEn_q;
  reg [7:0] shift_q;
  reg [3:0] bitCnt_q;
  reg masterRun_q;
  reg [4:0] toggleCnt_q;
  reg [5:0] divCnt_q;
  reg sckInt_q;
  reg [3:0] i2cState_q;
  reg matched_q;

  wire [3:0] mode = ctrl_q[3:0];
  wire en = ctrl_q[`SSP_CTL_EN];
  wire clock_polarity = ctrl_q[`SSP_CTL_CKP];
  wire cke = stat_q[`SSP_STA_CKE];
  wire sample_phase = stat_q[`SSP_STA_SMP];
  wire spiMaster = en && (mode[3:2] == 2'b00);
  wire spiSlave = en && (mode == `SSP_MODE_SPI_SS || mode == `SSP_MODE_SPI_NOSS);
  wire i2cAny = en && (mode == `SSP_MODE_I2C_7 || mode == `SSP_MODE_I2C_10 || mode == `SSP_MODE_I2C_FWM
    || mode == `SSP_MODE_I2C_7SP || mode == `SSP_MODE_I2C_10SP);
  wire i2cSlave = i2cAny && (mode != `SSP_MODE_I2C_FWM);
  wire i2cSpIrq = i2cAny && (mode == `SSP_MODE_I2C_FWM || mode[3:2] == 2'b11);
  wire i2cTenBit = mode[0];
  wire ssControl = (mode == `SSP_MODE_SPI_SS);
  wire ssReset = spiSlave && ssControl && ssS_n;
  wire spiOn = spiMaster ? masterRun_q : (spiSlave && !ssReset);

  wire wrBuf = regWr && regAddr == `SSP_REG_BUFFER;
  wire wrCtl = regWr && regAddr == `SSP_REG_CONTROL;
  wire wrSta = regWr && regAddr == `SSP_REG_STATUS;
  wire wrIrq = regWr && regAddr == `SSP_REG_IRQ;
  wire rdBuf = regRd && regAddr == `SSP_REG_BUFFER;

  // ----------------------------------------------------------------
  // Master clock divider, frozen in sleep
  // ----------------------------------------------------------------
  reg [5:0] halfPeriod;
  always @* begin
    case (mode[1:0])
      2'b00: halfPeriod = `SSP_HALF_DIV4;
      2'b01: halfPeriod = `SSP_HALF_DIV16;
      2'b10: halfPeriod = `SSP_HALF_DIV64;
      default: halfPeriod = `SSP_HALF_DIV4;
    endcase
  end
  wire divDone = (mode == `SSP_MODE_MTMR2) ? tmr2Tick : (divCnt_q == halfPeriod - 6'h01);
  wire mTick = spiMaster && masterRun_q && !sleepMode && divDone;

  // Edges seen by the shifter: internal toggles in master mode, pin edges in slave mode
  wire eRise = spiMaster ? (mTick && !sckInt_q) : sckRise;
  wire eFall = spiMaster ? (mTick && sckInt_q) : sckFall;
  wire leadEdge = clock_polarity ? eFall : eRise;
  wire trailEdge = clock_polarity ? eRise : eFall;
  wire outEdge = cke ? trailEdge : leadEdge;
  // Late sampling only applies to the master; a slave samples mid bit
  wire sampEdge = (sample_phase && spiMaster) ? outEdge : (cke ? leadEdge : trailEdge);
  wire doSample = spiOn && sampEdge;
  wire doOutput = spiOn && outEdge;
  wire byteDone = doSample && (bitCnt_q == `SSP_BITS - 4'h1);
  wire [7:0] rxByte = {shift_q[6:0], sdiS};
  wire spiBusy = spiMaster ? masterRun_q : (bitCnt_q != 4'h0);

  // ----------------------------------------------------------------
  // I2C events
  // ----------------------------------------------------------------
  wire i2cStart = i2cAny && sclS && sdaFall;
  wire i2cStop = i2cAny && sclS && sdaRise;
  wire i2cByteIn = i2cSlave && sclFall && (bitCnt_q == `SSP_BITS)
    && (i2cState_q == ST_ADDR || i2cState_q == ST_DATA);
  wire addrHit = i2cTenBit ? (shift_q[7:3] == 5'h1e && shift_q[2:1] == addr_q[2:1])
    : (shift_q[7:1] == addr_q[7:1]);
  wire byteOk = (i2cState_q == ST_DATA) || addrHit;
  wire overflowed = stat_q[`SSP_STA_BF] || ctrl_q[`SSP_CTL_OVF];
  wire ackNow = i2cByteIn && byteOk && !overflowed;

  // Byte events shared by both protocols
  wire rxDone = byteDone || (i2cByteIn && byteOk);
  wire [7:0] rxVal = byteDone ? rxByte : shift_q;
  wire rxStore = rxDone && !overflowed;

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (sys_rst) begin
      ctrl_q <= `SSP_CTL_RESET;
      stat_q <= `SSP_STA_RESET;
      buf_q <= 8'h00;
      addr_q <= 8'h00;
      irqFlag_q <= 1'b0;
      irqEn_q <= 1'b0;
    end else begin
      if (wrCtl) begin
        ctrl_q[5:0] <= regWrData[5:0];
        // Hardware set wins over a firmware clear in the same cycle
        ctrl_q[`SSP_CTL_WRITE_COLLISION] <= regWrData[`SSP_CTL_WRITE_COLLISION] | (wrBuf && spiBusy);
        ctrl_q[`SSP_CTL_OVF] <= regWrData[`SSP_CTL_OVF] | (rxDone && stat_q[`SSP_STA_BF]);
      end else begin
        if (wrBuf && spiBusy) begin
          ctrl_q[`SSP_CTL_WRITE_COLLISION] <= 1'b1;
        end
        if (rxDone && stat_q[`SSP_STA_BF]) begin
          ctrl_q[`SSP_CTL_OVF] <= 1'b1;
        end
      end
      if (wrSta) begin
        stat_q[7:6] <= regWrData[7:6];
      end
      if (!en) begin
        stat_q[`SSP_STA_START] <= 1'b0;
        stat_q[`SSP_STA_STOP] <= 1'b0;
      end else if (i2cStart) begin
        stat_q[`SSP_STA_START] <= 1'b1;
        stat_q[`SSP_STA_STOP] <= 1'b0;
      end else if (i2cStop) begin
        stat_q[`SSP_STA_START] <= 1'b0;
        stat_q[`SSP_STA_STOP] <= 1'b1;
      end
      if (rxStore) begin
        buf_q <= rxVal;
        stat_q[`SSP_STA_BF] <= 1'b1;
        if (i2cByteIn) begin
          stat_q[`SSP_STA_DA] <= (i2cState_q == ST_DATA);
          if (i2cState_q == ST_ADDR) begin
            stat_q[`SSP_STA_RW] <= shift_q[0];
          end
        end
      end else if (rdBuf) begin
        stat_q[`SSP_STA_BF] <= 1'b0;
      end
      if (wrBuf && !spiBusy) begin
        buf_q <= regWrData;
      end
      if (regWr && regAddr == `SSP_REG_ADDRESS) begin
        addr_q <= regWrData;
      end
      if (wrIrq) begin
        irqEn_q <= regWrData[`SSP_IRQ_ENABLE];
      end
      // Flag set on every SPI byte and every matched I2C byte, even when refused, and on Start/Stop when enabled
      if (rxDone || (i2cSpIrq && (i2cStart || i2cStop))) begin
        irqFlag_q <= 1'b1;
      end else if (wrIrq) begin
        irqFlag_q <= regWrData[`SSP_IRQ_FLAG];
      end
    end
  end

  // ----------------------------------------------------------------
  // Shifter, bit counter and master sequencing
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (sys_rst || !en) begin
      shift_q <= 8'h00;
      bitCnt_q <= 4'h0;
      masterRun_q <= 1'b0;
      toggleCnt_q <= 5'h00;
      divCnt_q <= 6'h00;
      sckInt_q <= 1'b0;
    end else begin
      if (!masterRun_q) begin
        sckInt_q <= clock_polarity;
      end
      if ((spiMaster || spiSlave) && wrBuf && !spiBusy) begin
        shift_q <= regWrData;
        masterRun_q <= spiMaster;
        divCnt_q <= 6'h00;
        toggleCnt_q <= 5'h00;
      end else if (ssReset) begin
        // Deselect clears only the bit count, so a byte loaded while idle survives
        bitCnt_q <= 4'h0;
      end else if (spiMaster || spiSlave) begin
        if (spiMaster && masterRun_q && !sleepMode) begin
          divCnt_q <= divDone ? 6'h00 : divCnt_q + 6'h01;
        end
        if (mTick) begin
          sckInt_q <= ~sckInt_q;
          toggleCnt_q <= toggleCnt_q + 5'h01;
          if (toggleCnt_q == `SSP_TOGGLES - 5'h01) begin
            masterRun_q <= 1'b0;
          end
        end
        if (doSample) begin
          shift_q <= rxByte;
          bitCnt_q <= byteDone ? 4'h0 : bitCnt_q + 4'h1;
        end
      end else if (i2cSlave) begin
        if (i2cStart || i2cStop) begin
          bitCnt_q <= 4'h0;
        end else if (sclRise && bitCnt_q != `SSP_BITS) begin
          shift_q <= {shift_q[6:0], sdaS};
          bitCnt_q <= bitCnt_q + 4'h1;
        end else if (sclFall && i2cState_q == ST_ACK) begin
          bitCnt_q <= 4'h0;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // I2C slave sequencer
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (sys_rst || !i2cSlave) begin
      i2cState_q <= ST_IDLE;
      matched_q <= 1'b0;
    end else if (i2cStart) begin
      i2cState_q <= ST_ADDR;
      matched_q <= 1'b0;
    end else if (i2cStop) begin
      i2cState_q <= ST_IDLE;
    end else begin
      case (i2cState_q)
        ST_ADDR: begin
          if (i2cByteIn) begin
            i2cState_q <= byteOk ? ST_ACK : ST_IDLE;
            matched_q <= byteOk && !shift_q[0];
          end
        end
        ST_DATA: begin
          if (i2cByteIn) begin
            i2cState_q <= ST_ACK;
          end
        end
        ST_ACK: begin
          // Reads are not served here, so a read address returns to idle
          if (sclFall) begin
            i2cState_q <= matched_q ? ST_DATA : ST_IDLE;
          end
        end
        ST_IDLE: i2cState_q <= ST_IDLE;
        default: i2cState_q <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Pin drivers, all registered
  // ----------------------------------------------------------------
  reg ackDrive_q;
  always @(posedge clk) begin
    if (sys_rst) begin
      ackDrive_q <= 1'b0;
    end else if (!i2cSlave || i2cStart || i2cStop) begin
      ackDrive_q <= 1'b0;
    end else if (ackNow) begin
      ackDrive_q <= 1'b1;
    end else if (i2cState_q == ST_ACK && sclFall) begin
      ackDrive_q <= 1'b0;
    end
  end

  always @(posedge clk) begin
    if (sys_rst) begin
      regRdData <= 8'h00;
      portIrq <= 1'b0;
      sckOut <= 1'b0;
      sckOe_n <= 1'b1;
      sdoOut <= 1'b0;
      sdoOe_n <= 1'b1;
      sdaOut <= 1'b0;
      sdaOe_n <= 1'b1;
      sclOut <= 1'b0;
      sclOe_n <= 1'b1;
    end else begin
      regRdData <= 8'h00;
      if (regRd) begin
        case (regAddr)
          `SSP_REG_BUFFER: regRdData <= buf_q;
          `SSP_REG_CONTROL: regRdData <= ctrl_q;
          `SSP_REG_STATUS: regRdData <= stat_q;
          `SSP_REG_IRQ: regRdData <= {6'h00, irqEn_q, irqFlag_q};
          `SSP_REG_ADDRESS: regRdData <= addr_q;
          default: regRdData <= 8'h00;
        endcase
      end
      portIrq <= irqFlag_q && irqEn_q;
      sckOut <= spiMaster ? sckInt_q : clock_polarity;
      sckOe_n <= !(spiMaster && !sckDirIn);
      // Next bit leaves on the output edge; with late sampling it is the bit after the shift
      if (wrBuf && !spiBusy) begin
        sdoOut <= regWrData[7];
      end else if (doOutput) begin
        sdoOut <= doSample ? shift_q[6] : shift_q[7];
      end
      // Slave-select high floats the output on the next edge, mid-byte or not
      sdoOe_n <= !((spiMaster || (spiSlave && !ssReset)) && !sdoDirIn);
      sdaOut <= 1'b0;
      sclOut <= 1'b0;
      // Pins only ever pull low, and only while firmware leaves them as inputs
      sdaOe_n <= !(i2cAny && sdaDirIn && sckDirIn && (ackDrive_q || ackNow));
      sclOe_n <= 1'b1;
    end
  end

endmodule // sync_serial_port

// *** sim/far_end_model.sv ***
// Purpose: External SPI master and bus master driving the serial port pins
// Assumes: Pins are sampled asynchronously by the port
// Notes: Serial clock stands still at its low idle level outside frames
`timescale 1ns/1ps
module far_end_model #(
  parameter integer HALF_NS = 200, // Serial clock half period
  parameter integer I2C_HALF_NS = 500 // Bus clock half period
) (
  output reg sck, // Serial clock
  output reg sdi, // Data toward the port
  output reg ssN, // Slave select
  output reg sdaDrv, // Bus data, 1 releases
  output reg sclDrv, // Bus clock, 1 releases
  input wire sdoLine, // Port data out on the wire
  input wire sdaLine // Bus data on the wire
);
  initial begin
    sck = 1'b0;
    sdi = 1'b1;
    ssN = 1'b1;
    sdaDrv = 1'b1;
    sclDrv = 1'b1;
  end

  // Data read just before the trailing edge, when the port's bit has settled
  task spiXfer(input [7:0] tx, input integer nBits, input useSs, output [7:0] rx);
    integer i;
    begin
      rx = 8'h00;
      ssN = ~useSs;
      #(HALF_NS);
      // Data changes mid low phase, so it is settled at either sampling edge
      for (i = 7; i > 7 - nBits; i = i - 1) begin
        #(HALF_NS / 2);
        sdi = tx[i];
        #(HALF_NS / 2);
        sck = 1'b1;
        #(HALF_NS);
        rx[i] = sdoLine;
        sck = 1'b0;
      end
      #(HALF_NS / 2);
      sdi = ~sdi;
      #(HALF_NS / 2);
      ssN = 1'b1;
    end
  endtask

  task i2cStart;
    begin
      sdaDrv = 1'b0;
      #(I2C_HALF_NS);
      sclDrv = 1'b0;
    end
  endtask

  task i2cStop;
    begin
      sdaDrv = 1'b0;
      #(I2C_HALF_NS);
      sclDrv = 1'b1;
      #(I2C_HALF_NS);
      sdaDrv = 1'b1;
      #(I2C_HALF_NS);
    end
  endtask

  task i2cByte(input [7:0] b, output ack);
    integer i;
    begin
      for (i = 7; i >= 0; i = i - 1) begin
        sdaDrv = b[i];
        #(I2C_HALF_NS);
        sclDrv = 1'b1;
        #(I2C_HALF_NS);
        sclDrv = 1'b0;
      end
      sdaDrv = 1'b1;
      #(I2C_HALF_NS);
      sclDrv = 1'b1;
      ack = ~sdaLine;
      #(I2C_HALF_NS);
      sclDrv = 1'b0;
    end
  endtask
endmodule // far_end_model

// *** sim/ssp_props.sv ***
// Purpose: Concurrent checks on the serial port pins and register port
// Assumes: Control bits 5:0 change only by bus writes to index 1
// Notes: Mode and enable are mirrored here from those writes
`timescale 1ns/1ps
module ssp_props (
  input wire clk, // Clock
  input wire sys_rst, // Reset
  input wire [2:0] regAddr, // Register index
  input wire [7:0] regWrData, // Write data
  input wire regWr, // Write strobe
  input wire regRd, // Read strobe
  input wire [7:0] regRdData, // Read data
  input wire sleepMode, // Asleep
  input wire sckOut, // Master clock level
  input wire sckOe_n, // Clock drive enable
  input wire sdoOe_n, // Data out enable
  input wire sdoDirIn, // Data out pin is input
  input wire ssIn_n, // Slave select
  input wire sdaOut, // Bus data level
  input wire sdaOe_n, // Bus data enable
  input wire sclOut, // Bus clock level
  input wire sclOe_n // Bus clock enable
);
  // ----------------------------------------------------------------
  // Mirror of the control register
  // ----------------------------------------------------------------
  reg [5:0] ctlQ;
  wire portOn = ctlQ[5];
  wire ssMode = portOn && ctlQ[3:0] == 4'h4;
  wire mstOn = portOn && ctlQ[3:2] == 2'b00;
  wire i2cOn = portOn && (ctlQ[3:1] == 3'b011 || ctlQ[3:1] == 3'b111);

  always @(posedge clk) begin
    if (sys_rst) begin
      ctlQ <= 6'h00;
    end else if (regWr && regAddr == 3'h1) begin
      ctlQ <= regWrData[5:0];
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  // Ack lasts across the ninth clock high phase, then is let go on its falling edge
  sequence ackHeld;
    !sdaOe_n [*4];
  endsequence
  sequence ackGone;
    sdaOe_n;
  endsequence

  ssDrive_a: assert property ((ssMode && !ssIn_n && !sdoDirIn) [*6] |-> !sdoOe_n)
    else $error("data out not driven while selected");
  ssRelease_a: assert property ((ssMode && ssIn_n) [*6] |-> sdoOe_n)
    else $error("data out still driven after deselect");
  dirInput_a: assert property (sdoDirIn [*3] |-> sdoOe_n)
    else $error("data out driven while pin is input");
  portOff_a: assert property ((!portOn) [*3] |-> sdoOe_n && sdaOe_n && sckOe_n)
    else $error("pin driven while port disabled");
  sckMaster_a: assert property (!sckOe_n |-> mstOn || $past(mstOn))
    else $error("clock driven outside master mode");
  ackMode_a: assert property (!sdaOe_n |-> i2cOn || $past(i2cOn))
    else $error("ack outside a slave bus mode");
  openDrain_a: assert property (!sdaOut && !sclOut && sclOe_n)
    else $error("bus pin driven high");
  ackSpan_a: assert property ($fell(sdaOe_n) |-> ackHeld ##[1:400] ackGone)
    else $error("ack pulse too short or never released");
  sleepHold_a: assert property (sleepMode && $past(sleepMode) |-> $stable(sckOut))
    else $error("master clock moved during sleep");
  rdIdle_a: assert property (!$past(regRd) |-> regRdData == 8'h00)
    else $error("read data outside its cycle");
endmodule // ssp_props

bind sync_serial_port ssp_props u_props (
  .clk(clk), .sys_rst(sys_rst), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
  .regRdData(regRdData), .sleepMode(sleepMode), .sckOut(sckOut), .sckOe_n(sckOe_n), .sdoOe_n(sdoOe_n),
  .sdoDirIn(sdoDirIn), .ssIn_n(ssIn_n), .sdaOut(sdaOut), .sdaOe_n(sdaOe_n), .sclOut(sclOut),
  .sclOe_n(sclOe_n)
);

// *** sim/testbench.sv ***
// Purpose: Self-checking bench for the synchronous serial port
// Assumes: 20 MHz clock, far end modelled with its own timing
// Notes: Lines with pull-ups are resolved here from all enables
`timescale 1ns/1ps
module testbench;
  reg clk = 1'b0;
  reg sys_rst = 1'b1;
  reg [2:0] regAddr = 3'h0;
  reg [7:0] regWrData = 8'h00;
  reg regWr = 1'b0;
  reg regRd = 1'b0;
  reg sleepMode = 1'b0;
  reg sdoDirIn = 1'b0;
  reg sckDirIn = 1'b1;
  wire [7:0] regRdData;
  wire portIrq, sckOut, sckOe_n, sdoOut, sdoOe_n, sdaOut, sdaOe_n, sclOut, sclOe_n;
  wire sck, sdi, ssN, sdaDrv, sclDrv;
  integer miscompares = 0;
  integer cmp_count = 0;
  integer cycles = 0;
  integer i;
  reg [7:0] rx;
  reg ack;
  reg [19:0] i2cModes = 20'hf67be;
  // A floating data out shows the inverse of its last level
  wire sdoLine = sdoOe_n ? ~sdoOut : sdoOut;
  wire sdaLine = sdaDrv & (sdaOe_n | sdaOut);
  wire sclLine = sclDrv & (sclOe_n | sclOut);

  sync_serial_port u_dut (
    .clk(clk), .sys_rst(sys_rst), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
    .regRdData(regRdData), .sleepMode(sleepMode), .tmr2Tick(1'b0), .portIrq(portIrq), .sckIn(sck),
    .sckOut(sckOut), .sckOe_n(sckOe_n), .sdiIn(sdi), .sdoOut(sdoOut), .sdoOe_n(sdoOe_n), .ssIn_n(ssN),
    .sdoDirIn(sdoDirIn), .sckDirIn(sckDirIn), .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe_n(sdaOe_n),
    .sclIn(sclLine), .sclOut(sclOut), .sclOe_n(sclOe_n), .sdaDirIn(1'b1)
  );
  far_end_model u_far (
    .sck(sck), .sdi(sdi), .ssN(ssN), .sdaDrv(sdaDrv), .sclDrv(sclDrv), .sdoLine(sdoLine), .sdaLine(sdaLine)
  );

  initial begin
    forever #25 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Bus and comparison helpers
  // ----------------------------------------------------------------
  task tick(input integer n);
    begin
      repeat (n) @(posedge clk);
      #1;
    end
  endtask
  task check(input [8*12-1:0] what, input [7:0] exp, input [7:0] got);
    begin
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
        miscompares = miscompares + 1;
        $display("[ERR] %0s expected %h seen %h", what, exp, got);
      end
    end
  endtask
  task wr(input [2:0] a, input [7:0] d);
    begin
      regAddr <= a;
      regWrData <= d;
      regWr <= 1'b1;
      @(posedge clk);
      regWr <= 1'b0;
      tick(1);
    end
  endtask
  task rd(input [2:0] a, input [7:0] mask, input [7:0] exp, input [8*12-1:0] what);
    begin
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge clk);
      regRd <= 1'b0;
      #1 check(what, exp, regRdData & mask);
      tick(1);
    end
  endtask
  task wrap_up;
    begin
      $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
    end
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares = miscompares + 1;
      wrap_up;
    end
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task tSpiSlave;
    begin
      rd(3'h1, 8'hff, 8'h00, "ctl reset");
      rd(3'h2, 8'hff, 8'h00, "sta reset");
      wr(3'h3, 8'h02);
      wr(3'h2, 8'h40);
      wr(3'h1, 8'h24);
      wr(3'h0, 8'hc3);
      sleepMode <= 1'b1;
      u_far.spiXfer(8'h96, 8, 1'b1, rx);
      tick(1);
      check("sdo bits", 8'hc3, rx);
      check("wake irq", 8'h01, {7'h0, portIrq});
      sleepMode <= 1'b0;
      rd(3'h2, 8'h01, 8'h01, "bf set");
      rd(3'h0, 8'hff, 8'h96, "rx byte");
      rd(3'h2, 8'h01, 8'h00, "bf clear");
    end
  endtask
  task tOverflow;
    begin
      u_far.spiXfer(8'h11, 8, 1'b1, rx);
      wr(3'h3, 8'h02);
      u_far.spiXfer(8'h22, 8, 1'b1, rx);
      tick(1);
      rd(3'h3, 8'h01, 8'h01, "ovf irq");
      rd(3'h1, 8'h40, 8'h40, "overflow");
      rd(3'h0, 8'hff, 8'h11, "kept byte");
      rd(3'h1, 8'h40, 8'h40, "ovf sticky");
      wr(3'h1, 8'h24);
      rd(3'h1, 8'h40, 8'h00, "ovf clear");
    end
  endtask
  task tAbort;
    begin
      u_far.spiXfer(8'hf0, 4, 1'b1, rx);
      tick(6);
      check("oe release", 8'h01, {7'h0, sdoOe_n});
      rd(3'h2, 8'h01, 8'h00, "no byte");
      u_far.spiXfer(8'h3c, 8, 1'b1, rx);
      tick(1);
      rd(3'h0, 8'hff, 8'h3c, "after abort");
      wr(3'h2, 8'h00);
      wr(3'h1, 8'h25);
      sdoDirIn <= 1'b1;
      u_far.spiXfer(8'ha5, 8, 1'b0, rx);
      tick(1);
      check("rx only oe", 8'h01, {7'h0, sdoOe_n});
      sdoDirIn <= 1'b0;
      rd(3'h0, 8'hff, 8'ha5, "no select");
    end
  endtask
  task tI2c;
    begin
      for (i = 0; i < 5; i = i + 1) begin
        wr(3'h1, {4'h0, i2cModes[i * 4 +: 4]});
        rd(3'h1, 8'hff, {4'h0, i2cModes[i * 4 +: 4]}, "mode code");
      end
      wr(3'h4, 8'h84);
      wr(3'h1, 8'h26);
      u_far.i2cStart;
      u_far.i2cByte(8'h84, ack);
      check("addr ack", 8'h01, {7'h0, ack});
      u_far.i2cByte(8'h5a, ack);
      check("full nack", 8'h00, {7'h0, ack});
      u_far.i2cStop;
      tick(1);
      rd(3'h0, 8'hff, 8'h84, "addr byte");
      rd(3'h1, 8'h40, 8'h40, "bus ovf");
      wr(3'h1, 8'h2e);
      wr(3'h3, 8'h02);
      u_far.i2cStart;
      tick(1);
      rd(3'h2, 8'h08, 8'h08, "start bit");
      rd(3'h3, 8'h01, 8'h01, "start irq");
      u_far.i2cByte(8'h90, ack);
      check("other addr", 8'h00, {7'h0, ack});
      u_far.i2cStop;
      tick(1);
      rd(3'h2, 8'h11, 8'h10, "stop bit");
      wr(3'h1, 8'h2b);
      u_far.i2cStart;
      u_far.i2cByte(8'h84, ack);
      check("idle slave", 8'h00, {7'h0, ack});
      u_far.i2cStop;
      wr(3'h1, 8'h27);
      u_far.i2cStart;
      u_far.i2cByte(8'hf4, ack);
      check("ten bit ack", 8'h01, {7'h0, ack});
      u_far.i2cStop;
      tick(1);
      rd(3'h0, 8'hff, 8'hf4, "ten bit addr");
    end
  endtask
  task tMaster;
    begin
      sckDirIn <= 1'b0;
      wr(3'h1, 8'h30);
      tick(2);
      check("idle high", 8'h01, {7'h0, sckOut});
      wr(3'h0, 8'h55);
      tick(4);
      sleepMode <= 1'b1;
      tick(40);
      rd(3'h2, 8'h01, 8'h00, "frozen");
      sleepMode <= 1'b0;
      tick(40);
      rd(3'h2, 8'h01, 8'h01, "resumed");
      rd(3'h0, 8'hff, 8'h00, "clear bf");
      wr(3'h0, 8'h0f);
      tick(4);
      sys_rst <= 1'b1;
      tick(2);
      sys_rst <= 1'b0;
      tick(2);
      check("rst drive", 8'h01, {7'h0, sckOe_n});
      rd(3'h1, 8'hff, 8'h00, "rst ctl");
    end
  endtask

  initial begin
    tick(2);
    sys_rst <= 1'b0;
    tick(1);
    tSpiSlave;
    tOverflow;
    tAbort;
    tI2c;
    tMaster;
    wrap_up;
  end
endmodule // testbench
